// >>> dv/pst_host_model.sv
// Bus initiator model that runs single and burst cycles.
module pst_host_model (
  input logic core_clk, // Bus clock.
  input logic [31:0] ad_bus, // Resolved data lines.
  input logic devsel_b, // Resolved select, low active.
  input logic trdy_b, // Resolved target ready.
  input logic stop_b, // Resolved stop.
  output logic frame_n, // Cycle frame.
  output logic irdy_n, // Initiator ready.
  output logic idsel, // Configuration select.
  output logic [3:0] cbe_n, // Command or byte enables.
  output logic [31:0] ad_drv // Lines driven by the initiator.
);
  timeunit 1ns;
  timeprecision 1ps;
  int dv_e;
  int tr_e;

  // Idle bus before the first cycle.
  initial begin
    frame_n = 1'b1;
    irdy_n = 1'b1;
    idsel = 1'b0;
    cbe_n = 4'hF;
    ad_drv = 32'h0;
  end

  // One cycle; st is {claimed, transferred, stopped}. Unless keep is set, released
  // lines turn to the inverse of their last value so stale data never matches.
  task automatic cyc(input logic [3:0] cmd, input logic [31:0] a,
      input logic sel, input logic [3:0] be, input logic [31:0] wd,
      input logic burst, input logic fast, input logic keep,
      output logic [2:0] st, output logic [31:0] rd);
    st = 3'b000;
    rd = 32'h0;
    dv_e = 0;
    tr_e = 0;
    if (!fast) @(posedge core_clk);
    frame_n <= 1'b0;
    idsel <= sel;
    cbe_n <= cmd;
    ad_drv <= a;
    @(posedge core_clk);
    idsel <= 1'b0;
    cbe_n <= ~be;
    irdy_n <= 1'b0;
    frame_n <= ~burst;
    ad_drv <= cmd[0] ? wd : ~a;
    for (int k = 1; k < 9 && st[1:0] == 2'b00; k++) begin
      @(posedge core_clk);
      if (!devsel_b && dv_e == 0) dv_e = k;
      st[2] = st[2] | ~devsel_b;
      if (!trdy_b) begin
        tr_e = k;
        rd = ad_bus;
        st[1:0] = {1'b1, ~stop_b};
      end else if (!stop_b) st[1:0] = 2'b01;
    end
    // A held frame is dropped first, as a stopped initiator must.
    if (!frame_n) begin
      frame_n <= 1'b1;
      @(posedge core_clk);
    end
    irdy_n <= 1'b1;
    if (!keep) begin
      cbe_n <= ~cbe_n;
      ad_drv <= ~ad_drv;
    end
  endtask
endmodule

// >>> dv/test_pst_slave_host_port_unit.sv
// Self-checking bench of the PCI slave target port.
module test_pst_slave_host_port_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import pst_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h1357_2468; // Arbitrary value.
  logic core_clk = 1'b0;
  logic arst_n;
  logic eeprom_busy;
  logic frame_n, irdy_n, idsel, ad_oe_n, devsel_n, trdy_n, stop_n, ctl_oe_n;
  logic [3:0] cbe_n;
  logic [31:0] ad_drv, ad_in, ad_out, res_rdata;
  pst_res_t res;
  pst_res_t res_q[$];
  int fails = 0;
  int num_checks = 0;
  logic [31:0] rnd = 32'hFEE3;
  logic [1:0] m_cmd = 2'h0;
  logic [26:0] m_io = 27'h0;
  logic [26:0] m_mem = 27'h0;
  logic [11:0] m_rom = 12'h000;
  logic m_ren = 1'b0;
  logic [5:0] idx_l[6] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h05, 6'h0C};
  logic [3:0] bad_l[7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD};
  logic [3:0] cmd_l[7] = '{CMD_IO_WR, CMD_IO_RD, CMD_MEM_WR, CMD_MEM_RD,
    CMD_MEM_RD_MULT, CMD_MEM_RD_LINE, CMD_MEM_WR_INV};

  // Wire resolution: the target wins the data lines while it drives them.
  assign ad_in = ad_oe_n ? ad_drv : ad_out;
  assign res_rdata = {res.space, 10'h000, res.addr} ^ 32'h5A5A_0000;

  always #2 core_clk = ~core_clk;

  // Every internal request is queued for the scenario to compare.
  always @(posedge core_clk) if (res.req) res_q.push_back(res);

  pst_slave_host_port_unit #(.ID_WORD(ID_VAL)) u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .frame_n(frame_n),
    .irdy_n(irdy_n), .idsel(idsel), .cbe_n(cbe_n), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe_n(ad_oe_n), .devsel_n(devsel_n),
    .trdy_n(trdy_n), .stop_n(stop_n), .ctl_oe_n(ctl_oe_n),
    .eeprom_busy(eeprom_busy), .res(res), .res_rdata(res_rdata));

  pst_host_model u_host (
    .core_clk(core_clk), .ad_bus(ad_in), .devsel_b(ctl_oe_n | devsel_n),
    .trdy_b(ctl_oe_n | trdy_n), .stop_b(ctl_oe_n | stop_n),
    .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel), .cbe_n(cbe_n),
    .ad_drv(ad_drv));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected configuration word from the model state.
  function automatic logic [31:0] cfg_exp(input logic [5:0] i);
    case (i)
      CFG_IDX_ID: return ID_VAL;
      CFG_IDX_CMD: return {8'h00, 8'h80, 14'h0000, m_cmd};
      CFG_IDX_IOBAR: return {m_io, 5'h01};
      CFG_IDX_MEMBAR: return {m_mem, 5'h00};
      CFG_IDX_ROMBAR: return {m_rom, 19'h00000, m_ren};
      default: return 32'h0;
    endcase
  endfunction

  task automatic chk(input string what, input logic [63:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One access with status, timing, data and internal request compared.
  task automatic acc(input logic [3:0] cmd, input logic [31:0] a,
      input logic sel, input logic [3:0] be, input logic [31:0] wd,
      input logic [2:0] sx, input logic [31:0] rx, input pst_res_t e,
      input logic burst = 1'b0);
    logic [2:0] st;
    logic [31:0] rd;
    pst_res_t r;
    u_host.cyc(cmd, a, sel, be, wd, burst, 1'b0, 1'b0, st, rd);
    repeat (2) @(posedge core_clk);
    rnd = lfsr(rnd);
    chk("status", st, sx);
    if (st[1] && !cmd[0]) chk("read data", rd, rx);
    if (st[2]) chk("devsel edge", u_host.dv_e, 2);
    if (st[1]) chk("trdy edge", u_host.tr_e, 3);
    chk("requests", res_q.size(), e.req);
    if (res_q.size() > 0) begin
      r = res_q.pop_front();
      chk("request", r >> 32, e >> 32);
      if (e.write) chk("write data", r.wdata, e.wdata);
    end
  endtask

  // Byte-merged configuration write, then a read back.
  task automatic cfg_wr(input logic [5:0] i, input logic [3:0] be,
      input logic [31:0] wd);
    logic [31:0] m, v;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    v = (cfg_exp(i) & ~m) | (wd & m);
    acc(CMD_CFG_WR, {rnd[31:8], i, 2'b00}, 1, be, wd, 6, 0, RES_RST);
    if (i == CFG_IDX_CMD) m_cmd = v[1:0];
    if (i == CFG_IDX_IOBAR) m_io = v[31:5];
    if (i == CFG_IDX_MEMBAR) m_mem = v[31:5];
    if (i == CFG_IDX_ROMBAR) m_rom = v[31:20];
    if (i == CFG_IDX_ROMBAR) m_ren = v[0];
    acc(CMD_CFG_RD, {rnd[31:8], i, 2'b00}, 1, 4'hF, 0, 6, cfg_exp(i),
      RES_RST);
  endtask

  // Main sequence; a hung cycle shows as a status mismatch.
  initial begin
    logic [4:0] off;
    logic [31:0] a;
    logic [3:0] be;
    logic [1:0] sp;
    logic [2:0] st;
    logic [31:0] rd;
    pst_res_t e;
    arst_n = 1'b0;
    eeprom_busy = 1'b1;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    acc(CMD_CFG_RD, 0, 1, 4'hF, 0, 5, 0, RES_RST);
    eeprom_busy <= 1'b0;
    acc(CMD_CFG_RD, 0, 1, 4'hF, 0, 6, ID_VAL, RES_RST);
    foreach (idx_l[j]) acc(CMD_CFG_RD, {rnd[31:8], idx_l[j], 2'b00}, 1,
      4'hF, 0, 6, cfg_exp(idx_l[j]), RES_RST);
    acc(CMD_CFG_RD, 32'h5, 1, 4'hF, 0, 0, 0, RES_RST);
    acc(CMD_CFG_RD, 32'h6, 1, 4'hF, 0, 0, 0, RES_RST);
    acc(CMD_CFG_RD, 32'h4, 0, 4'hF, 0, 0, 0, RES_RST);
    cfg_wr(CFG_IDX_IOBAR, 4'hF, {rnd[31:5], 5'h1E});
    acc(CMD_IO_RD, {m_io, 5'h00}, 0, 4'hF, 0, 0, 0, RES_RST);
    cfg_wr(CFG_IDX_MEMBAR, 4'hF, {4'hA, rnd[27:0]});
    cfg_wr(CFG_IDX_ROMBAR, 4'hC, {4'h5, rnd[27:0]});
    cfg_wr(CFG_IDX_ROMBAR, 4'h1, 32'h0000_00FF);
    cfg_wr(CFG_IDX_CMD, 4'h1, 32'hFFFF_FF03);
    foreach (cmd_l[j]) begin
      off = {rnd[4:2], 2'b00};
      be = rnd[11:8] | 4'h1;
      sp = (cmd_l[j][3:1] == 3'h1) ? SPACE_IO : SPACE_MEM;
      a = (sp == SPACE_IO) ? {m_io, off} : {m_mem, off};
      e = {1'b1, cmd_l[j][0], sp, 15'h0000, off, be, rnd};
      acc(cmd_l[j], a, 0, be, rnd, 6, {sp, 25'h0, off} ^ 32'h5A5A_0000,
        e);
    end
    acc(CMD_IO_RD, {m_io + 27'h1, 5'h00}, 0, 4'hF, 0, 0, 0,
      RES_RST);
    a = {m_rom, rnd[19:2], 2'b00};
    e = {1'b1, 1'b0, SPACE_ROM, a[19:0], 4'hF, 32'h0};
    acc(CMD_MEM_RD, a, 0, 4'hF, 0, 6, {SPACE_ROM, 10'h0, a[19:0]} ^
      32'h5A5A_0000, e);
    acc(CMD_MEM_WR, a, 0, 4'hF, rnd, 6, 0, RES_RST);
    foreach (bad_l[j]) acc(bad_l[j], {m_io, 5'h00}, 1, 4'hF, 0, 0, 0,
      RES_RST);
    acc(CMD_CFG_RD, 32'h4, 1, 4'hF, 0, 7, cfg_exp(CFG_IDX_CMD), RES_RST,
      1'b1);
    eeprom_busy <= 1'b1;
    acc(CMD_IO_RD, {m_io, 5'h00}, 0, 4'hF, 0, 5, 0, RES_RST);
    eeprom_busy <= 1'b0;
    u_host.cyc(CMD_MEM_RD, 32'h100, 0, 4'hF, 0, 0, 0, 1, st, rd);
    u_host.cyc(CMD_CFG_RD, 32'h14, 1, 4'hF, 0, 0, 1, 0, st, rd);
    chk("back to back", {st, rd}, {3'h6, cfg_exp(CFG_IDX_MEMBAR)});
    end_of_test();
  end

  // Overall limit in case a wait never ends.
  initial begin
    #150000;
    fails++;
    end_of_test();
  end
endmodule

// >>> rtl/pst_cfg_space.sv
// Configuration space words that steer the address decode.
module pst_cfg_space #(
  parameter logic [31:0] ID_WORD = 32'h0001_0001 // Arbitrary value.
) (
  input logic core_clk, // Bus clock.
  input logic arst_n, // Asynchronous reset, active low.
  input logic wr_en, // One-cycle write strobe.
  input logic [5:0] idx, // Word index.
  input logic [3:0] be, // Byte enables, active high.
  input logic [31:0] wdata, // Write data.
  output logic [31:0] rdata, // Read data of the indexed word.
  output pst_pkg::pst_map_t map // Decode settings.
);
  import pst_pkg::*;

  logic [1:0] cmd_ff;
  logic [26:0] io_base_ff;
  logic [26:0] mem_base_ff;
  logic rom_en_ff;
  logic [11:0] rom_base_ff;
  logic [31:0] nxt_word;

  // Merge the enabled bytes of a write into the current word.
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] en);
    logic [31:0] w;
    w = old_w;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        w[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return w;
  endfunction

  // Read mux; unimplemented words read as zero.
  always_comb begin
    rdata = 32'h0000_0000;
    case (idx)
      CFG_IDX_ID: rdata = ID_WORD;
      CFG_IDX_CMD: begin
        rdata[1:0] = cmd_ff;
        rdata[STAT_FBB_BIT] = 1'b1; // [RL16]
      end
      CFG_IDX_IOBAR: begin
        rdata[31:WIN_LSB] = io_base_ff; // [RL19]
        rdata[IOBAR_SPACE_BIT] = 1'b1;
      end
      CFG_IDX_MEMBAR: rdata[31:WIN_LSB] = mem_base_ff; // [RL19]
      CFG_IDX_ROMBAR: begin
        rdata[31:ROM_LSB] = rom_base_ff; // [RL20]
        rdata[ROM_EN_BIT] = rom_en_ff;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  assign nxt_word = merge(rdata, wdata, be); // [RL11]

  // Register writes; a read-only bit is simply never stored.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ff <= CMD_RST;
      io_base_ff <= BASE_RST;
      mem_base_ff <= BASE_RST;
      rom_en_ff <= 1'b0;
      rom_base_ff <= ROM_BASE_RST;
    end else if (wr_en) begin
      case (idx)
        CFG_IDX_CMD: cmd_ff <= nxt_word[1:0];
        CFG_IDX_IOBAR: io_base_ff <= nxt_word[31:WIN_LSB];
        CFG_IDX_MEMBAR: mem_base_ff <= nxt_word[31:WIN_LSB];
        CFG_IDX_ROMBAR: begin
          rom_base_ff <= nxt_word[31:ROM_LSB];
          rom_en_ff <= nxt_word[ROM_EN_BIT];
        end
        default: ;
      endcase
    end
  end

  // One driver for the whole word keeps every tool happy with the struct.
  assign map = '{io_en: cmd_ff[CMD_IOEN_BIT], mem_en: cmd_ff[CMD_MEMEN_BIT],
                 io_base: io_base_ff, mem_base: mem_base_ff,
                 rom_en: rom_en_ff, rom_base: rom_base_ff};
endmodule

// >>> rtl/pst_pkg.sv
// Shared constants and types of the PCI slave target port.
package pst_pkg;
  // Bus command codes seen on the byte enable lines in the address phase.
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

  // Address bits below these positions lie inside a window.
  localparam int WIN_LSB = 5;
  localparam int ROM_LSB = 20;

  // Configuration space word indices held by this block.
  localparam logic [5:0] CFG_IDX_ID = 6'h00;
  localparam logic [5:0] CFG_IDX_CMD = 6'h01;
  localparam logic [5:0] CFG_IDX_IOBAR = 6'h04;
  localparam logic [5:0] CFG_IDX_MEMBAR = 6'h05;
  localparam logic [5:0] CFG_IDX_ROMBAR = 6'h0C;

  // Field positions inside configuration words.
  localparam int CMD_IOEN_BIT = 0;
  localparam int CMD_MEMEN_BIT = 1;
  localparam int STAT_FBB_BIT = 23;
  localparam int ROM_EN_BIT = 0;
  localparam int IOBAR_SPACE_BIT = 0;

  // Values after reset.
  localparam logic [1:0] CMD_RST = 2'h0;
  localparam logic [26:0] BASE_RST = 27'h0000000;
  localparam logic [11:0] ROM_BASE_RST = 12'h000;

  // Resource spaces on the internal access port.
  localparam logic [1:0] SPACE_IO = 2'h0;
  localparam logic [1:0] SPACE_MEM = 2'h1;
  localparam logic [1:0] SPACE_ROM = 2'h2;

  // Kind of access claimed in an address phase.
  typedef enum logic [2:0] {
    KIND_NONE, KIND_CFG, KIND_IO, KIND_MEM, KIND_ROM
  } pst_kind_t;

  // One request to the internal register resources or boot ROM.
  typedef struct packed {
    logic req;
    logic write;
    logic [1:0] space;
    logic [19:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pst_res_t;

  // Decode settings taken from configuration space.
  typedef struct packed {
    logic io_en;
    logic mem_en;
    logic [26:0] io_base;
    logic [26:0] mem_base;
    logic rom_en;
    logic [11:0] rom_base;
  } pst_map_t;

  localparam pst_res_t RES_RST = '0;
endpackage

// >>> rtl/pst_slave_host_port_unit.sv
// PCI slave target: decode, medium DEVSEL, fixed data phase, disconnects.

// Operation
// RL1: I/O read returns data from the internal register resources.
// RL2: I/O write stores into the addressed internal register.
// RL3: Memory read serves mapped registers, or the boot ROM in its window.
// RL4: Memory write stores into the mapped internal registers.
// RL5: Configuration read returns a configuration space word.
// RL6: Configuration write stores into configuration space.
// RL7: Read multiple and read line act as read; write invalidate as write.
// RL8: Configuration claimed only with IDSEL high and address bits 1:0 zero.
// RL9: Address bits 7:2 pick the configuration word.
// RL10: Address bits 31:8 are ignored on configuration accesses.
// RL11: Byte enables pick the bytes; 8, 16 and 32-bit transfers work.
// RL12: DEVSEL goes active two clocks after FRAME goes active.
// RL13: TRDY goes active on the third clock of the data phase.
// RL14: A second data phase is answered with a disconnect.
// RL15: While the EEPROM loads, claimed accesses end in retry.
// RL16: Fast back-to-back capable status bit reads as one.
// RL17: An address phase right after another target's data phase is seen.
// RL18: Register resources span 32 bytes on a 32-byte aligned base.
// RL19: I/O and memory base registers place the register window.
// RL20: Boot ROM of 1 Mbyte sits on a 1-Mbyte aligned base.
// RL21: Busy disconnect drives STOP with DEVSEL, TRDY idle, until the end.
// RL22: I/O and memory accesses are claimed only when enabled.
// RL23: Acknowledge, special, dual address and reserved codes are ignored.
// RL24: The initiator retries until the access completes normally.
module pst_slave_host_port_unit #(
  parameter logic [31:0] ID_WORD = 32'h0001_0001 // Arbitrary value.
) (
  input logic core_clk, // Bus clock.
  input logic arst_n, // Asynchronous reset, active low.
  input logic frame_n, // Cycle frame, active low.
  input logic irdy_n, // Initiator ready, active low.
  input logic idsel, // Configuration select, active high.
  input logic [3:0] cbe_n, // Command or byte enables, active low.
  input logic [31:0] ad_in, // Address and data from the bus.
  output logic [31:0] ad_out, // Read data onto the bus.
  output logic ad_oe_n, // Low while this block drives the data lines.
  output logic devsel_n, // Device select, active low.
  output logic trdy_n, // Target ready, active low.
  output logic stop_n, // Stop, active low.
  output logic ctl_oe_n, // Low while DEVSEL, TRDY and STOP are driven.
  input logic eeprom_busy, // EEPROM load in progress, active high.
  output pst_pkg::pst_res_t res, // Request to internal resources.
  input logic [31:0] res_rdata // Reply, valid while a read request is high.
);
  import pst_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CLAIM, ST_WAIT, ST_DATA, ST_TERM, ST_TURN
  } pst_state_t;

  pst_state_t state_ff;
  pst_state_t nxt_state;
  pst_kind_t kind_ff;
  pst_kind_t dec_kind;
  pst_map_t map;
  pst_res_t res_ff;
  logic frame_q_ff;
  logic write_ff;
  logic retry_ff;
  logic [31:0] addr_ff;
  logic [3:0] be_ff;
  logic [31:0] ad_out_ff;
  logic ad_oe_n_ff;
  logic devsel_n_ff;
  logic trdy_n_ff;
  logic stop_n_ff;
  logic ctl_oe_n_ff;
  logic start;
  logic take;
  logic xfer;
  logic done_term;
  logic cfg_wr;
  logic [31:0] cfg_rdata;

  // True when an address falls in a 32-byte window at the given base.
  function automatic logic win_hit(input logic [31:0] a,
                                   input logic [26:0] base);
    return a[31:WIN_LSB] == base; // [RL18]
  endfunction

  // Decide which kind of access, if any, an address phase claims.
  function automatic pst_kind_t decode(input logic [3:0] c,
                                       input logic sel,
                                       input logic [31:0] a,
                                       input pst_map_t m);
    pst_kind_t k;
    k = KIND_NONE;
    case (c)
      CMD_CFG_RD, CMD_CFG_WR: begin
        if (sel && a[1:0] == 2'h0) begin
          k = KIND_CFG; // [RL5] [RL6] [RL8] [RL10]
        end
      end
      CMD_IO_RD, CMD_IO_WR: begin
        if (m.io_en && win_hit(a, m.io_base)) begin
          k = KIND_IO; // [RL19] [RL22]
        end
      end
      CMD_MEM_RD, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE, CMD_MEM_WR,
      CMD_MEM_WR_INV: begin
        if (m.mem_en && win_hit(a, m.mem_base)) begin
          k = KIND_MEM; // [RL7] [RL19] [RL22]
        end else if (m.mem_en && m.rom_en &&
                     a[31:ROM_LSB] == m.rom_base) begin
          k = KIND_ROM; // [RL3] [RL20]
        end
      end
      default: k = KIND_NONE; // [RL23]
    endcase
    return k;
  endfunction

  // Configuration words live in their own small register file.
  pst_cfg_space #(
    .ID_WORD(ID_WORD)
  ) u_cfg (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(cfg_wr),
    .idx(addr_ff[7:2]),
    .be(~cbe_n),
    .wdata(ad_in),
    .rdata(cfg_rdata),
    .map(map)
  );

  // An address phase is the first clock with FRAME low. The idle level
  // of IRDY is not required, so a phase that directly follows another
  // target's last data phase is still caught.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_q_ff <= 1'b1;
    end else begin
      frame_q_ff <= frame_n;
    end
  end

  assign start = frame_q_ff && !frame_n; // [RL17]
  assign dec_kind = decode(cbe_n, idsel, ad_in, map);
  assign take = start && dec_kind != KIND_NONE &&
                (state_ff == ST_IDLE || state_ff == ST_TURN);
  assign xfer = state_ff == ST_DATA && !irdy_n;
  assign done_term = state_ff == ST_TERM && frame_n && !irdy_n;
  assign cfg_wr = xfer && write_ff && kind_ff == KIND_CFG; // [RL6] [RL9]

  // Cycle sequence; every claimed access that is not retried reaches the data state after the same fixed wait.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE, ST_TURN: nxt_state = take ? ST_CLAIM : ST_IDLE;
      ST_CLAIM: nxt_state = retry_ff ? ST_TERM : ST_WAIT;
      ST_WAIT: nxt_state = ST_DATA;
      ST_DATA: begin
        if (xfer) begin
          nxt_state = !frame_n ? ST_TERM : ST_TURN;
        end
      end
      ST_TERM: nxt_state = done_term ? ST_TURN : ST_TERM;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Latch the address phase. The busy level is caught here so that a
  // load ending mid-cycle cannot turn a retry into a half transfer.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      kind_ff <= KIND_NONE;
      write_ff <= 1'b0;
      retry_ff <= 1'b0;
      addr_ff <= 32'h0000_0000;
    end else if (take) begin
      kind_ff <= dec_kind;
      write_ff <= cbe_n[0]; // [RL7]
      retry_ff <= eeprom_busy; // [RL15]
      addr_ff <= ad_in;
    end
  end

  // Byte enables of the data phase, held but not used; the read request takes cbe_n directly.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      be_ff <= 4'h0;
    end else if (state_ff == ST_CLAIM) begin
      be_ff <= ~cbe_n; // [RL11]
    end
  end

  // Target control lines. DEVSEL waits one clock past the fast slot,
  // which leaves a full turnaround after another target lets go.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      devsel_n_ff <= 1'b1;
      trdy_n_ff <= 1'b1;
      stop_n_ff <= 1'b1;
      ctl_oe_n_ff <= 1'b1;
    end else begin
      case (state_ff)
        ST_CLAIM: begin
          devsel_n_ff <= 1'b0; // [RL12]
          ctl_oe_n_ff <= 1'b0;
          if (retry_ff) begin
            stop_n_ff <= 1'b0; // [RL15] [RL21]
          end
        end
        ST_WAIT: begin
          trdy_n_ff <= 1'b0; // [RL13]
          if (!frame_n && !irdy_n) begin
            stop_n_ff <= 1'b0; // [RL14]
          end
        end
        ST_DATA: begin
          if (xfer) begin
            trdy_n_ff <= 1'b1;
            if (!frame_n) begin
              stop_n_ff <= 1'b0; // [RL14]
            end else begin
              devsel_n_ff <= 1'b1;
              stop_n_ff <= 1'b1;
            end
          end
        end
        ST_TERM: begin
          if (done_term) begin
            devsel_n_ff <= 1'b1; // [RL21]
            stop_n_ff <= 1'b1;
          end
        end
        ST_TURN: ctl_oe_n_ff <= 1'b1;
        default: ;
      endcase
    end
  end

  // Data lines. The first data clock is left free for turnaround.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ad_oe_n_ff <= 1'b1;
      ad_out_ff <= 32'h0000_0000;
    end else begin
      if (state_ff == ST_CLAIM && !retry_ff && !write_ff) begin
        ad_oe_n_ff <= 1'b0;
      end else if (xfer || done_term) begin
        ad_oe_n_ff <= 1'b1;
      end
      if (state_ff == ST_WAIT) begin
        if (kind_ff == KIND_CFG) begin
          ad_out_ff <= cfg_rdata; // [RL5] [RL9]
        end else begin
          ad_out_ff <= res_rdata; // [RL1] [RL3]
        end
      end
    end
  end

  // Internal resource port. Reads are asked once per access, so a read
  // with side effects is never repeated by a slow initiator. Writes to
  // the boot ROM window are accepted on the bus and dropped.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_ff <= RES_RST;
    end else begin
      res_ff.req <= 1'b0;
      if (state_ff == ST_CLAIM && !retry_ff && !write_ff &&
          kind_ff != KIND_CFG) begin
        res_ff.req <= 1'b1; // [RL1] [RL3]
        res_ff.write <= 1'b0;
        res_ff.be <= ~cbe_n;
      end else if (xfer && write_ff &&
                   (kind_ff == KIND_IO || kind_ff == KIND_MEM)) begin
        res_ff.req <= 1'b1; // [RL2] [RL4]
        res_ff.write <= 1'b1;
        res_ff.be <= ~cbe_n; // [RL11]
        res_ff.wdata <= ad_in;
      end
      if (state_ff == ST_CLAIM) begin
        case (kind_ff)
          KIND_IO: res_ff.space <= SPACE_IO;
          KIND_MEM: res_ff.space <= SPACE_MEM;
          default: res_ff.space <= SPACE_ROM;
        endcase
        if (kind_ff == KIND_ROM) begin
          res_ff.addr <= addr_ff[19:0]; // [RL20]
        end else begin
          res_ff.addr <= {15'h0000, addr_ff[4:0]}; // [RL18]
        end
      end
    end
  end

  assign ad_out = ad_out_ff;
  assign ad_oe_n = ad_oe_n_ff;
  assign devsel_n = devsel_n_ff;
  assign trdy_n = trdy_n_ff;
  assign stop_n = stop_n_ff;
  assign ctl_oe_n = ctl_oe_n_ff;
  assign res = res_ff;

  // Checks on the bus timing and decode.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_medium_devsel;
    devsel_n_ff ##1 devsel_n_ff ##1 !devsel_n_ff;
  endsequence

  sequence s_trdy_third;
    ##2 trdy_n_ff ##1 !trdy_n_ff;
  endsequence

  sequence s_quiet;
    ##1 devsel_n_ff [*3];
  endsequence

  property p_devsel_medium;
    take |-> s_medium_devsel;
  endproperty
  a_devsel_medium: assert property (p_devsel_medium) // [RL12]
    else $error("DEVSEL not on the medium decode slot");

  property p_trdy_third;
    take && !eeprom_busy |-> s_trdy_third;
  endproperty
  a_trdy_third: assert property (p_trdy_third) // [RL13]
    else $error("TRDY not on the third data clock");

  property p_retry_busy;
    take && eeprom_busy |->
      ##2 (!stop_n_ff && !devsel_n_ff && trdy_n_ff);
  endproperty
  a_retry_busy: assert property (p_retry_busy) // [RL15]
    else $error("Busy access not ended by retry");

  property p_stop_hold;
    !stop_n_ff && !frame_n |=> !stop_n_ff && trdy_n_ff;
  endproperty
  a_stop_hold: assert property (p_stop_hold) // [RL21]
    else $error("STOP released before FRAME went high");

  property p_burst_stop;
    xfer && !frame_n |=> !stop_n_ff && trdy_n_ff && !devsel_n_ff;
  endproperty
  a_burst_stop: assert property (p_burst_stop) // [RL14]
    else $error("Second data phase not disconnected");

  property p_rsvd_ignored;
    start && state_ff == ST_IDLE &&
      (cbe_n inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD})
      |-> s_quiet;
  endproperty
  a_rsvd_ignored: assert property (p_rsvd_ignored) // [RL23]
    else $error("Unused command code was claimed");

  property p_cfg_select;
    start && state_ff == ST_IDLE &&
      (cbe_n == CMD_CFG_RD || cbe_n == CMD_CFG_WR) &&
      (!idsel || ad_in[1:0] != 2'h0) |-> s_quiet;
  endproperty
  a_cfg_select: assert property (p_cfg_select) // [RL8]
    else $error("Configuration claimed without select");

  property p_io_enable;
    start && state_ff == ST_IDLE && !map.io_en &&
      (cbe_n == CMD_IO_RD || cbe_n == CMD_IO_WR) |-> s_quiet;
  endproperty
  a_io_enable: assert property (p_io_enable) // [RL22]
    else $error("I/O access claimed while disabled");

  property p_fbb_bit;
    addr_ff[7:2] == CFG_IDX_CMD |-> cfg_rdata[STAT_FBB_BIT];
  endproperty
  a_fbb_bit: assert property (p_fbb_bit) // [RL16]
    else $error("Fast back-to-back bit reads zero");

  property p_write_req;
    xfer && write_ff && (kind_ff == KIND_IO || kind_ff == KIND_MEM)
      |=> res_ff.req && res_ff.write && res_ff.wdata == $past(ad_in);
  endproperty
  a_write_req: assert property (p_write_req) // [RL2] [RL4]
    else $error("Register write not passed on");

  property p_read_req;
    state_ff == ST_CLAIM && !retry_ff && !write_ff &&
      kind_ff != KIND_CFG |=> res_ff.req && !res_ff.write ##1 !res_ff.req;
  endproperty
  a_read_req: assert property (p_read_req) // [RL1] [RL3]
    else $error("Register read request not a single pulse");
endmodule
